//--- verilog/touch_screen_engine.sv
// Purpose: Touch acquisition engine for resistive or capacitive panels.
// Assumes: ADC, tag buffer and power controller share clk_sys.
// Notes: One coefficient set serves whichever panel kind is fitted.
`timescale 1ns/10ps
module touch_screen_engine
	import tse_pkg::*;
#(
	parameter int ACQ_CYC = ACQ_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic panel_capacitive,
	input wire logic [1:0] power_state,
	input wire logic frame_sync,
	input wire logic core_irq_n,
	output logic adc_start,
	output logic [1:0] adc_channel,
	input wire logic adc_done,
	input wire logic [9:0] adc_data,
	input wire logic touch_sense,
	input wire logic short_detect,
	output logic [3:0] axis_o,
	output logic [3:0] axis_oe,
	output logic tag_req,
	output logic [15:0] tag_x,
	output logic [15:0] tag_y,
	input wire logic tag_ack,
	input wire logic [7:0] tag_value,
	input wire logic panel_module_irq_in_n,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic panel_module_rst_n,
	output logic host_int_n_o,
	output logic host_int_n_oe,
	output logic touch_detect
);
	typedef struct packed {
		tse_state_e st;
		tse_job_e job;
		logic [1:0] res_mode;
		logic [1:0] cap_mode;
		logic [1:0] eng_rst;
		logic [15:0] thresh;
		logic sh_en;
		logic lp_en;
		logic halt;
		logic mts;
		logic [NUM_COEFF-1:0][31:0] coef;
		logic [CFG_SLOTS-1:0][16:0] cfg;
		logic [31:0] rraw;
		logic [15:0] rz;
		logic [NUM_TOUCH-1:0][31:0] craw;
		logic [NUM_TOUCH-1:0][31:0] scr;
		logic [NUM_TOUCH-1:0][7:0] tag;
		logic [31:0] tag_xy;
		logic [9:0] adx;
		logic [9:0] ady;
		logic [2:0] idx;
		logic [2:0] cnt;
		logic [4:0] step;
		logic [3:0] cslot;
		logic [23:0] acc;
		logic shot_p;
		logic frame_p;
		logic lp_p;
		logic cfg_p;
		logic [15:0] ms_cnt;
		logic [9:0] prst_cnt;
		logic [3:0] pdrv;
		logic [3:0] plvl;
		logic adc_go;
		logic i2c_go;
		logic [31:0] rdata;
		logic [1:0] irq_s;
		logic [1:0] sense_s;
		logic [1:0] short_s;
	} tse_core_s;
	tse_core_s q;
	tse_core_s n;
	tse_i2c_if i2c ();
	logic [31:0] mat_raw;
	logic [31:0] mat_scr;
	logic ok_run;
	logic tick;
	logic touched;
	logic ext;
	logic tag_need;
	logic [4:0] b;
	logic [2:0] k;

	tse_matrix u_matrix (
		.coef(q.coef),
		.raw(mat_raw),
		.screen(mat_scr)
	);

	tse_i2c u_i2c (
		.clk_sys(clk_sys),
		.rst(rst),
		.bus(i2c.engine),
		.scl_i(scl_i),
		.scl_oe(scl_oe),
		.sda_i(sda_i),
		.sda_oe(sda_oe)
	);

	assign ext = ~q.mts;
	assign mat_raw = panel_capacitive ? q.craw[q.idx] : q.rraw;
	assign ok_run = (power_state == PWR_ACTIVE) && !q.halt && (q.eng_rst != ENG_HOLD);
	assign tick = (q.res_mode == MODE_CONT) && (q.ms_cnt == 16'(ACQ_CYC - 1));
	assign touched = q.sense_s[1] && ({6'h00, adc_data} < q.thresh);
	assign tag_need = (q.idx < q.cnt) && (q.idx == 3'd0 || (ext && panel_capacitive));
	assign b = q.step - 5'd4;
	assign k = 3'(b >> 2);

	always_comb begin
		n = q;
		n.adc_go = 1'b0;
		n.i2c_go = 1'b0;
		n.rdata = 32'h0000_0000;
		n.irq_s = {q.irq_s[0], panel_module_irq_in_n};
		n.sense_s = {q.sense_s[0], touch_sense};
		n.short_s = {q.short_s[0], short_detect};
		n.ms_cnt = (q.res_mode != MODE_CONT || tick) ? 16'h0000 : q.ms_cnt + 16'h0001;
		if (q.prst_cnt != 10'h000) begin
			n.prst_cnt = q.prst_cnt - 10'h001;
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_RES_MODE: n.rdata = {30'h0, q.res_mode};
				OFS_RES_RAW: n.rdata = q.rraw;
				OFS_RES_SCREEN, OFS_CAP_SCREEN, OFS_MT_COORDS0: n.rdata = q.scr[0];
				OFS_TAG: n.rdata = {24'h0, q.tag[0]};
				OFS_TAG_XY: n.rdata = q.tag_xy;
				OFS_PRESSURE: n.rdata = {16'h0, q.rz};
				OFS_THRESHOLD: n.rdata = {16'h0, q.thresh};
				OFS_CONFIG: n.rdata = {23'h0, q.halt, 6'h0, q.lp_en, q.sh_en};
				OFS_CAP_MODE: n.rdata = {30'h0, q.cap_mode};
				OFS_CAP_RAW: n.rdata = q.craw[0];
				OFS_MT_SELECT: n.rdata = {31'h0, q.mts};
				OFS_MT_COORDS0 + 8'h04: n.rdata = q.scr[1];
				OFS_MT_COORDS0 + 8'h08: n.rdata = q.scr[2];
				OFS_MT_COORDS0 + 8'h0C: n.rdata = q.scr[3];
				OFS_FIFTH_X: n.rdata = {16'h0, q.scr[4][31:16]};
				OFS_FIFTH_Y: n.rdata = {16'h0, q.scr[4][15:0]};
				OFS_TAGS_LO: n.rdata = q.tag[3:0];
				OFS_TAGS_HI: n.rdata = {24'h0, q.tag[4]};
				OFS_ENGINE_RESET: n.rdata = {30'h0, q.eng_rst};
				default: begin
					if (reg_addr >= OFS_COEFF0 && reg_addr < OFS_COEFF0 + 8'(4 * NUM_COEFF)) begin
						n.rdata = q.coef[3'((reg_addr - OFS_COEFF0) >> 2)];
					end else if (reg_addr >= OFS_CFG_MEM0
						&& reg_addr < OFS_CFG_MEM0 + 8'(4 * CFG_SLOTS)) begin
						n.rdata = {15'h0, q.cfg[4'((reg_addr - OFS_CFG_MEM0) >> 2)]};
					end
				end
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				OFS_RES_MODE: begin
					n.res_mode = reg_wdata[1:0];
					n.shot_p = (reg_wdata[1:0] == MODE_SINGLE) | q.shot_p;
				end
				OFS_THRESHOLD: n.thresh = reg_wdata[15:0];
				OFS_CONFIG: begin
					n.sh_en = reg_wdata[CFG_SHORT_EN_BIT];
					n.lp_en = reg_wdata[CFG_LOWPWR_BIT];
					n.halt = q.halt & reg_wdata[CFG_SHORT_EN_BIT];
					if (reg_wdata[CFG_LOWPWR_BIT] && !q.lp_en) begin
						n.lp_p = 1'b1;
					end
					if (!reg_wdata[CFG_LOWPWR_BIT] && q.lp_en) begin
						n.prst_cnt = 10'(PANEL_RST_CYC);
					end
				end
				OFS_CAP_MODE: n.cap_mode = reg_wdata[1:0];
				OFS_MT_SELECT: n.mts = reg_wdata[0];
				OFS_ENGINE_RESET: begin
					n.eng_rst = reg_wdata[1:0];
					if (q.eng_rst == ENG_HOLD && reg_wdata[1:0] == ENG_RUN) begin
						n.cfg_p = 1'b1;
						n.cslot = 4'h0;
					end
				end
				default: begin
					if (reg_addr >= OFS_COEFF0 && reg_addr < OFS_COEFF0 + 8'(4 * NUM_COEFF)) begin
						n.coef[3'((reg_addr - OFS_COEFF0) >> 2)] = reg_wdata;
					end else if (reg_addr >= OFS_CFG_MEM0
						&& reg_addr < OFS_CFG_MEM0 + 8'(4 * CFG_SLOTS)) begin
						n.cfg[4'((reg_addr - OFS_CFG_MEM0) >> 2)] = reg_wdata[16:0];
					end
				end
			endcase
		end
		if (frame_sync && q.res_mode == MODE_FRAME) begin
			n.frame_p = 1'b1;
		end
		if (q.short_s[1] && q.sh_en) begin
			n.halt = 1'b1;
		end
		case (q.st)
			ST_IDLE: begin
				n.pdrv = 4'h0;
				n.idx = 3'd0;
				n.step = 5'd0;
				if (q.cfg_p && (q.cslot == 4'(CFG_SLOTS) || !q.cfg[q.cslot][CFG_VALID_BIT])) begin
					n.cfg_p = 1'b0;
				end else if (q.cfg_p && q.eng_rst == ENG_RUN) begin
					n.job = JOB_CFG;
					n.i2c_go = 1'b1;
					n.st = ST_I2C;
				end else if (q.lp_p) begin
					n.lp_p = 1'b0;
					n.job = JOB_LOWPWR;
					n.i2c_go = 1'b1;
					n.st = ST_I2C;
				end else if (ok_run && !panel_capacitive && q.res_mode != MODE_OFF
					&& (q.shot_p || q.frame_p || tick)) begin
					n.shot_p = 1'b0;
					n.frame_p = frame_sync && q.res_mode == MODE_FRAME;
					n.pdrv = 4'b0011;
					n.plvl = 4'b0001;
					n.adc_go = 1'b1;
					n.st = ST_RX;
				end else if (ok_run && panel_capacitive && q.cap_mode == MODE_CONT
					&& !q.lp_en && !q.irq_s[1]) begin
					n.job = JOB_READ;
					n.i2c_go = 1'b1;
					n.st = ST_I2C;
				end
			end
			ST_RX: if (adc_done) begin
				n.adx = adc_data;
				n.pdrv = 4'b1100;
				n.plvl = 4'b0100;
				n.adc_go = 1'b1;
				n.st = ST_RY;
			end
			ST_RY: if (adc_done) begin
				n.ady = adc_data;
				n.pdrv = 4'b1001;
				n.plvl = 4'b0001;
				n.adc_go = 1'b1;
				n.st = ST_RZ;
			end
			ST_RZ: if (adc_done) begin
				n.pdrv = 4'h0;
				n.st = ST_XFM;
				n.cnt = touched ? 3'd1 : 3'd0;
				n.rraw = touched ? {6'h00, q.adx, 6'h00, q.ady} : RAW_NONE;
				n.rz = touched ? {6'h00, adc_data} : RZ_NONE;
			end
			ST_I2C: if (i2c.done) begin
				if (q.job == JOB_READ && q.step == 5'd3) begin
					n.cnt = (i2c.rbyte[2:0] > 3'(NUM_TOUCH)) ? 3'(NUM_TOUCH) : i2c.rbyte[2:0];
				end else if (q.job == JOB_READ && q.step > 5'd3) begin
					n.acc = {q.acc[15:0], i2c.rbyte};
					if (b[1:0] == 2'd3) begin
						n.craw[k] = {q.acc, i2c.rbyte};
					end
				end
				n.step = q.step + 5'd1;
				n.i2c_go = 1'b1;
				if (q.job == JOB_READ && q.step == READ_LAST_STEP) begin
					n.i2c_go = 1'b0;
					n.st = ST_XFM;
				end else if (q.job != JOB_READ && q.step == WRITE_LAST_STEP) begin
					n.i2c_go = 1'b0;
					n.cslot = q.cslot + ((q.job == JOB_CFG) ? 4'h1 : 4'h0);
					n.st = ST_IDLE;
				end
			end
			ST_XFM: begin
				n.scr[q.idx] = (q.idx < q.cnt) ? mat_scr : SCR_NONE;
				if (panel_capacitive && q.idx >= q.cnt) begin
					n.craw[q.idx] = RAW_NONE;
				end
				n.idx = q.idx + 3'd1;
				if (!panel_capacitive || q.idx == 3'(NUM_TOUCH - 1)) begin
					n.idx = 3'd0;
					n.st = ST_TAG;
				end
			end
			ST_TAG: begin
				if (!tag_need || tag_ack) begin
					n.tag[q.idx] = tag_need ? tag_value : 8'h00;
					if (tag_need && q.idx == 3'd0) begin
						n.tag_xy = q.scr[0];
					end
					n.idx = q.idx + 3'd1;
					if (!panel_capacitive || q.idx == 3'(NUM_TOUCH - 1)) begin
						n.st = ST_IDLE;
					end
				end
			end
			default: n.st = ST_IDLE;
		endcase
		if (n.halt && (q.st == ST_RX || q.st == ST_RY || q.st == ST_RZ)) begin
			n.pdrv = 4'h0;
			n.st = ST_IDLE;
		end
	end

	always_comb begin
		i2c.req = q.i2c_go;
		i2c.start = (q.step == 5'd0) || (q.job == JOB_READ && q.step == 5'd2);
		i2c.rd = (q.job == JOB_READ) && (q.step > 5'd2);
		i2c.nack = (q.step == READ_LAST_STEP);
		i2c.stop = (q.job == JOB_READ) ? (q.step == READ_LAST_STEP) : (q.step == WRITE_LAST_STEP);
		case (q.step)
			5'd0: i2c.wbyte = {PANEL_I2C_ADDR, 1'b0};
			5'd1: i2c.wbyte = (q.job == JOB_READ) ? PANEL_DATA_REG
				: (q.job == JOB_CFG) ? q.cfg[q.cslot][15:8] : PANEL_PWR_REG;
			5'd2: i2c.wbyte = (q.job == JOB_READ) ? {PANEL_I2C_ADDR, 1'b1}
				: (q.job == JOB_CFG) ? q.cfg[q.cslot][7:0] : PANEL_PWR_LOW;
			default: i2c.wbyte = 8'hFF;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '{st: ST_IDLE, job: JOB_READ, mts: MT_SELECT_RST, thresh: THRESH_RST,
				rraw: RAW_NONE, rz: RZ_NONE, craw: {NUM_TOUCH{RAW_NONE}},
				scr: {NUM_TOUCH{SCR_NONE}}, tag_xy: SCR_NONE, irq_s: 2'b11,
				default: '0};
		end else begin
			q <= n;
		end
	end

	assign reg_rdata = q.rdata;
	assign adc_start = q.adc_go;
	assign adc_channel = (q.st == ST_RY) ? 2'd1 : (q.st == ST_RZ) ? 2'd2 : 2'd0;
	assign axis_o = q.plvl;
	assign axis_oe = q.halt ? 4'h0 : q.pdrv;
	assign tag_req = (q.st == ST_TAG) && tag_need;
	assign tag_x = q.scr[q.idx][31:16];
	assign tag_y = q.scr[q.idx][15:0];
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign panel_module_rst_n = (q.prst_cnt == 10'h000);
	assign host_int_n_o = 1'b0;
	assign touch_detect = panel_capacitive ? ~q.irq_s[1] : q.sense_s[1];
	always_comb begin
		if (power_state == PWR_ACTIVE) begin
			host_int_n_oe = ~core_irq_n;
		end else if (panel_capacitive) begin
			host_int_n_oe = ~q.irq_s[1];
		end else begin
			host_int_n_oe = (power_state != PWR_DOWN) && q.sense_s[1];
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_off_no_start: assert property (q.st == ST_IDLE && q.res_mode == MODE_OFF && !panel_capacitive
		|=> q.st != ST_RX) else $error("acquisition started in off mode");
	a_single_start: assert property (q.st == ST_IDLE && q.shot_p && ok_run && !panel_capacitive
		&& q.res_mode == MODE_SINGLE && !q.cfg_p && !q.lp_p |=> q.st == ST_RX && adc_start)
		else $error("single acquisition not started");
	a_frame_start: assert property (frame_sync && q.res_mode == MODE_FRAME |=> q.frame_p
		|| q.st == ST_RX) else $error("frame sync lost");
	a_ms_period: assert property (q.ms_cnt < 16'(ACQ_CYC)) else $error("period counter overran");
	a_untouch_raw: assert property (q.st == ST_RZ && adc_done && !touched
		|=> q.rraw == RAW_NONE && q.rz == RZ_NONE) else $error("untouched raw wrong");
	a_untouch_scr: assert property (q.st == ST_XFM && q.cnt == 3'd0 && !panel_capacitive
		|=> q.scr[0] == SCR_NONE) else $error("untouched screen wrong");
	a_short_float: assert property (q.short_s[1] && q.sh_en |=> q.halt && axis_oe == 4'h0 [*2])
		else $error("short did not float lines");
	a_cap_mirror: assert property (power_state != PWR_ACTIVE && panel_capacitive
		|-> host_int_n_oe == !$past(q.irq_s[0])) else $error("interrupt not mirrored");
	a_res_wake: assert property (power_state != PWR_ACTIVE && power_state != PWR_DOWN
		&& !panel_capacitive && q.sense_s[1] |-> host_int_n_oe) else $error("no wake");
	a_cfg_release: assert property (reg_wr && reg_addr == OFS_ENGINE_RESET && q.eng_rst == ENG_HOLD
		&& reg_wdata[1:0] == ENG_RUN |=> q.cfg_p) else $error("release lost");
	a_lp_reset: assert property (reg_wr && reg_addr == OFS_CONFIG && q.lp_en
		&& !reg_wdata[CFG_LOWPWR_BIT] |=> !panel_module_rst_n [*8]) else $error("no reset");
endmodule

//--- include/tse_pkg.sv
// Purpose: Shared constants and types of the touch screen engine.
// Assumes: 50 MHz system clock; 32-bit register port with byte offsets.
// Notes: Panel module addresses and register numbers are plain defaults.
package tse_pkg;
	localparam int CLK_MHZ = 50;
	localparam int ACQ_PERIOD_US = 1000;
	localparam int ACQ_CYCLES = ACQ_PERIOD_US * CLK_MHZ;
	localparam int I2C_KHZ = 100;
	localparam int I2C_QTR_CYC = (CLK_MHZ * 1000) / (4 * I2C_KHZ);
	localparam int PANEL_RST_US = 10;
	localparam int PANEL_RST_CYC = PANEL_RST_US * CLK_MHZ;
	localparam logic [7:0] OFS_RES_MODE = 8'h00;
	localparam logic [7:0] OFS_RES_RAW = 8'h04;
	localparam logic [7:0] OFS_RES_SCREEN = 8'h08;
	localparam logic [7:0] OFS_TAG = 8'h0C;
	localparam logic [7:0] OFS_TAG_XY = 8'h10;
	localparam logic [7:0] OFS_PRESSURE = 8'h14;
	localparam logic [7:0] OFS_THRESHOLD = 8'h18;
	localparam logic [7:0] OFS_CONFIG = 8'h1C;
	localparam logic [7:0] OFS_CAP_MODE = 8'h20;
	localparam logic [7:0] OFS_CAP_RAW = 8'h24;
	localparam logic [7:0] OFS_CAP_SCREEN = 8'h28;
	localparam logic [7:0] OFS_MT_SELECT = 8'h2C;
	localparam logic [7:0] OFS_MT_COORDS0 = 8'h30;
	localparam logic [7:0] OFS_FIFTH_X = 8'h40;
	localparam logic [7:0] OFS_FIFTH_Y = 8'h44;
	localparam logic [7:0] OFS_TAGS_LO = 8'h48;
	localparam logic [7:0] OFS_TAGS_HI = 8'h4C;
	localparam logic [7:0] OFS_ENGINE_RESET = 8'h50;
	localparam logic [7:0] OFS_COEFF0 = 8'h54;
	localparam logic [7:0] OFS_CFG_MEM0 = 8'h80;
	localparam int NUM_COEFF = 6;
	localparam int NUM_TOUCH = 5;
	localparam int CFG_SLOTS = 10;
	localparam int CFG_VALID_BIT = 16;
	localparam int CFG_SHORT_EN_BIT = 0;
	localparam int CFG_LOWPWR_BIT = 1;
	localparam int CFG_HALT_BIT = 8;
	localparam logic [31:0] RAW_NONE = 32'hFFFF_FFFF;
	localparam logic [31:0] SCR_NONE = 32'h8000_8000;
	localparam logic [15:0] RZ_NONE = 16'h7FFF;
	localparam logic [15:0] THRESH_RST = 16'hFFFF;
	localparam logic MT_SELECT_RST = 1'b1;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_FRAME = 2'h2;
	localparam logic [1:0] MODE_CONT = 2'h3;
	localparam logic [1:0] ENG_RUN = 2'h0;
	localparam logic [1:0] ENG_HOLD = 2'h2;
	localparam logic [1:0] PWR_ACTIVE = 2'h0;
	localparam logic [1:0] PWR_DOWN = 2'h3;
	localparam logic [6:0] PANEL_I2C_ADDR = 7'h2A;
	localparam logic [7:0] PANEL_DATA_REG = 8'h10;
	localparam logic [7:0] PANEL_PWR_REG = 8'h20;
	localparam logic [7:0] PANEL_PWR_LOW = 8'h01;
	localparam logic [4:0] READ_LAST_STEP = 5'd23;
	localparam logic [4:0] WRITE_LAST_STEP = 5'd2;
	typedef enum logic [3:0] {I2C_IDLE = 4'b0001, I2C_START = 4'b0010,
		I2C_BIT = 4'b0100, I2C_STOP = 4'b1000} tse_i2c_state_e;
	typedef enum logic [6:0] {ST_IDLE = 7'b0000001, ST_RX = 7'b0000010, ST_RY = 7'b0000100,
		ST_RZ = 7'b0001000, ST_I2C = 7'b0010000, ST_XFM = 7'b0100000,
		ST_TAG = 7'b1000000} tse_state_e;
	typedef enum logic [1:0] {JOB_READ = 2'h0, JOB_CFG = 2'h1, JOB_LOWPWR = 2'h2} tse_job_e;
endpackage

//--- include/tse_i2c_if.sv
// Purpose: Byte-level request and answer between engine and I2C master.
// Assumes: One request at a time; req is a one-cycle pulse.
// Notes: done pulses once per byte, after the stop when one was asked.
`timescale 1ns/10ps
interface tse_i2c_if;
	logic req;
	logic start;
	logic stop;
	logic rd;
	logic nack;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic done;
	logic ack;
	modport master (output req, start, stop, rd, nack, wbyte, input rbyte, done, ack);
	modport engine (input req, start, stop, rd, nack, wbyte, output rbyte, done, ack);
endinterface

//--- verilog/tse_matrix.sv
// Purpose: Six-coefficient affine transform from raw to screen coordinates.
// Assumes: Coefficients are signed 16.16 fixed point.
// Notes: Results saturate; the low limit stays above the no-touch code.
`timescale 1ns/10ps
module tse_matrix
	import tse_pkg::*;
(
	input wire logic [NUM_COEFF-1:0][31:0] coef,
	input wire logic [31:0] raw,
	output logic [31:0] screen
);
	logic signed [15:0] xs;
	logic signed [15:0] ys;
	logic signed [49:0] sx;
	logic signed [49:0] sy;

	function automatic logic [15:0] sat(input logic signed [49:0] v);
		if (v > 50'sd32767) begin
			sat = 16'h7FFF;
		end else if (v < -50'sd32767) begin
			sat = 16'h8001;
		end else begin
			sat = v[15:0];
		end
	endfunction

	always_comb begin
		xs = signed'(raw[31:16]);
		ys = signed'(raw[15:0]);
		sx = ($signed(coef[0]) * xs + $signed(coef[1]) * ys + $signed(coef[2])) >>> 16;
		sy = ($signed(coef[3]) * xs + $signed(coef[4]) * ys + $signed(coef[5])) >>> 16;
		screen = {sat(sx), sat(sy)};
	end
endmodule

//--- verilog/tse_i2c.sv
// Purpose: Open-drain I2C byte engine for the panel module link.
// Assumes: Lines are pulled up outside; the module may stretch the clock.
// Notes: A bit takes four quarter periods; scl is held low between bytes.
`timescale 1ns/10ps
module tse_i2c
	import tse_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	tse_i2c_if.engine bus,
	input wire logic scl_i,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_oe
);
	typedef struct packed {
		tse_i2c_state_e st;
		logic [1:0] ph;
		logic [6:0] div;
		logic [3:0] nb;
		logic [8:0] sh;
		logic sda_low;
		logic scl_low;
		logic stop;
		logic done;
		logic ack;
		logic [7:0] rbyte;
		logic [1:0] sda_s;
		logic [1:0] scl_s;
	} tse_i2c_s;
	tse_i2c_s q;
	tse_i2c_s n;
	logic tick;

	always_comb begin
		n = q;
		n.done = 1'b0;
		n.sda_s = {q.sda_s[0], sda_i};
		n.scl_s = {q.scl_s[0], scl_i};
		tick = (q.div == 7'(I2C_QTR_CYC - 1)) && !(q.ph == 2'd1 && !q.scl_s[1]);
		n.div = (q.div == 7'(I2C_QTR_CYC - 1)) ? 7'h00 : q.div + 7'h01;
		case (q.st)
			I2C_IDLE: begin
				n.div = 7'h00;
				if (bus.req) begin
					n.sh = bus.rd ? {8'hFF, bus.nack} : {bus.wbyte, 1'b1};
					n.stop = bus.stop;
					n.ph = 2'd0;
					n.nb = 4'h0;
					n.st = bus.start ? I2C_START : I2C_BIT;
				end
			end
			I2C_START: if (tick) begin
				n.ph = q.ph + 2'd1;
				if (q.ph == 2'd0) begin
					n.sda_low = 1'b0;
					n.scl_low = 1'b0;
				end else if (q.ph == 2'd1) begin
					n.sda_low = 1'b1;
				end else if (q.ph == 2'd2) begin
					n.scl_low = 1'b1;
				end else begin
					n.st = I2C_BIT;
				end
			end
			I2C_BIT: if (tick) begin
				n.ph = q.ph + 2'd1;
				if (q.ph == 2'd0) begin
					n.sda_low = ~q.sh[8];
				end else if (q.ph == 2'd1) begin
					n.scl_low = 1'b0;
				end else if (q.ph == 2'd2) begin
					n.sh = {q.sh[7:0], q.sda_s[1]};
				end else begin
					n.scl_low = 1'b1;
					n.nb = q.nb + 4'h1;
					if (q.nb == 4'h8) begin
						n.rbyte = q.sh[8:1];
						n.ack = ~q.sh[0];
						n.done = ~q.stop;
						n.st = q.stop ? I2C_STOP : I2C_IDLE;
					end
				end
			end
			I2C_STOP: if (tick) begin
				n.ph = q.ph + 2'd1;
				if (q.ph == 2'd0) begin
					n.sda_low = 1'b1;
				end else if (q.ph == 2'd1) begin
					n.scl_low = 1'b0;
				end else if (q.ph == 2'd2) begin
					n.sda_low = 1'b0;
				end else begin
					n.done = 1'b1;
					n.st = I2C_IDLE;
				end
			end
			default: n.st = I2C_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '{st: I2C_IDLE, default: '0};
		end else begin
			q <= n;
		end
	end

	assign scl_oe = q.scl_low;
	assign sda_oe = q.sda_low;
	assign bus.done = q.done;
	assign bus.ack = q.ack;
	assign bus.rbyte = q.rbyte;
endmodule

//--- dv/tse_panel_model.sv
// Purpose: Panel, converter and tag buffer facing the engine.
// Assumes: A conversion answers five cycles after its start.
// Notes: The tag is the inverted low byte of X.
`timescale 1ns/10ps
module tse_panel_model
	import tse_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic adc_start,
	input wire logic [1:0] adc_channel,
	input wire logic [29:0] vals,
	output logic adc_done,
	output logic [9:0] adc_data,
	input wire logic tag_req,
	input wire logic [15:0] tag_x,
	output logic tag_ack,
	output logic [7:0] tag_value
);
	logic [2:0] cnt;
	logic [1:0] ch;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			ch <= 2'h0;
			adc_done <= 1'b0;
			adc_data <= 10'h0;
			tag_ack <= 1'b0;
			tag_value <= 8'h0;
		end else begin
			cnt <= adc_start ? 3'h4 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
			ch <= adc_start ? adc_channel : ch;
			adc_done <= cnt == 3'h1;
			adc_data <= (cnt == 3'h1) ? vals[ch * 10 +: 10] : ~adc_data;
			tag_ack <= tag_req && !tag_ack;
			tag_value <= (tag_req && !tag_ack) ? ~tag_x[7:0] : ~tag_value;
		end
	end
endmodule

//--- dv/touch_screen_engine_tb.sv
// Purpose: Self-checking bench of the resistive touch path.
// Assumes: Identity matrix; the panel model answers conversions and tags.
// Notes: The capacitive link stays idle.
`timescale 1ns/10ps
module touch_screen_engine_tb;
	import tse_pkg::*;
	localparam int ACQ = 200;
	logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, frame_sync = 0;
	logic touch_sense = 0, short_detect = 0, adc_start, adc_done, tag_req, tag_ack;
	logic scl_oe, sda_oe, host_oe;
	logic [7:0] reg_addr = 0, tag_value;
	logic [31:0] reg_wdata = 0, reg_rdata, e;
	logic [1:0] power_state = 0, adc_channel;
	logic [9:0] adc_data;
	logic [29:0] vals = 0;
	logic [3:0] axis_oe;
	logic [15:0] tag_x;
	int err_count = 0, n_checks = 0, starts = 0, s0, x, y, z;
	touch_screen_engine #(.ACQ_CYC(ACQ)) u_touch_screen_engine (.clk_sys(clk_sys),
		.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .panel_capacitive(1'b0),
		.power_state(power_state), .frame_sync(frame_sync), .core_irq_n(1'b1),
		.adc_start(adc_start), .adc_channel(adc_channel), .adc_done(adc_done),
		.adc_data(adc_data), .touch_sense(touch_sense), .short_detect(short_detect),
		.axis_o(), .axis_oe(axis_oe), .tag_req(tag_req), .tag_x(tag_x), .tag_y(),
		.tag_ack(tag_ack), .tag_value(tag_value), .panel_module_irq_in_n(1'b1),
		.scl_i(!scl_oe), .scl_o(), .scl_oe(scl_oe), .sda_i(!sda_oe), .sda_o(),
		.sda_oe(sda_oe), .panel_module_rst_n(), .host_int_n_o(),
		.host_int_n_oe(host_oe), .touch_detect());
	tse_panel_model u_tse_panel_model (.clk_sys(clk_sys), .rst(rst),
		.adc_start(adc_start), .adc_channel(adc_channel), .vals(vals),
		.adc_done(adc_done), .adc_data(adc_data), .tag_req(tag_req),
		.tag_x(tag_x), .tag_ack(tag_ack), .tag_value(tag_value));
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (adc_start === 1'b1) starts++;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] ex);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		n_checks++;
		if (reg_rdata !== ex) begin
			err_count++;
			$display("ERROR %0t reg %h got %h want %h", $time, a, reg_rdata, ex);
		end
	endtask
	task automatic chk_pin(input logic v);
		n_checks++;
		if (v !== 1'b1) begin
			err_count++;
			$display("ERROR %0t pin check", $time);
		end
	endtask
	task automatic pulse();
		@(posedge clk_sys);
		frame_sync <= 1'b1;
		@(posedge clk_sys);
		frame_sync <= 1'b0;
	endtask
	task automatic acquire(input logic [1:0] m);
		s0 = starts;
		wr(OFS_RES_MODE, 32'(m));
		if (m == MODE_FRAME) pulse();
		repeat (400) if (starts < s0 + 3) @(posedge clk_sys);
		repeat (40) @(posedge clk_sys);
	endtask
	task automatic summarize();
		$display("Checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#100us;
		err_count++;
		summarize();
	end
	initial begin
		s0 = $urandom(2);
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		chk(OFS_RES_RAW, RAW_NONE);
		chk(OFS_RES_SCREEN, SCR_NONE);
		chk(OFS_TAG_XY, SCR_NONE);
		chk(OFS_PRESSURE, 32'(RZ_NONE));
		chk(OFS_MT_SELECT, 32'(MT_SELECT_RST));
		chk(8'hFC, 32'h0);
		wr(OFS_COEFF0, 32'h0001_0000);
		wr(OFS_COEFF0 + 8'h10, 32'h0001_0000);
		touch_sense <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			x = $urandom_range(1023);
			y = $urandom_range(1023);
			z = $urandom_range(900);
			vals <= {10'(z), 10'(y), 10'(x)};
			if (i == 3) wr(OFS_THRESHOLD, 32'(z));
			acquire(2'(i % 2 + 1));
			e = (i == 3) ? RAW_NONE : {6'h0, 10'(x), 6'h0, 10'(y)};
			chk(OFS_RES_RAW, e);
			chk(OFS_PRESSURE, (i == 3) ? 32'(RZ_NONE) : 32'(z));
			if (i < 3) begin
				chk(OFS_RES_SCREEN, e);
				chk(OFS_TAG_XY, e);
				chk(OFS_TAG, {24'h0, ~8'(x)});
			end
		end
		wr(OFS_RES_MODE, 32'(MODE_OFF));
		s0 = starts;
		pulse();
		repeat (3 * ACQ) @(posedge clk_sys);
		chk_pin(starts == s0);
		chk_pin(u_touch_screen_engine.touch_detect === 1'b1);
		wr(OFS_RES_MODE, 32'(MODE_CONT));
		s0 = starts;
		repeat (2 * ACQ + 100) @(posedge clk_sys);
		chk_pin(starts - s0 >= 6 && starts - s0 <= 9);
		power_state <= 2'h1;
		repeat (60) @(posedge clk_sys);
		s0 = starts;
		repeat (2 * ACQ) @(posedge clk_sys);
		chk_pin(starts == s0);
		chk_pin(host_oe === 1'b1);
		power_state <= PWR_DOWN;
		repeat (5) @(posedge clk_sys);
		chk_pin(host_oe === 1'b0);
		power_state <= PWR_ACTIVE;
		wr(OFS_CONFIG, 32'h1);
		short_detect <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk_pin(axis_oe === 4'h0);
		chk(OFS_CONFIG, 32'h101);
		wr(OFS_ENGINE_RESET, 32'(ENG_HOLD));
		wr(OFS_CFG_MEM0, 32'h0001_3344);
		chk(OFS_ENGINE_RESET, 32'(ENG_HOLD));
		chk(OFS_CFG_MEM0, 32'h0001_3344);
		wr(OFS_ENGINE_RESET, 32'(ENG_RUN));
		chk(OFS_ENGINE_RESET, 32'(ENG_RUN));
		summarize();
	end
endmodule
